/* File: spcs_pkg.sv */
// How it works
// - pll reference comes only from alternate path
// - pre-divider 1..15, multiplier 1..255 only
// - post-divider 1,2,4,8; output dividers powers of two 2..256
// - output rate is ref*M/(N*O*C)
// - outputs start on one common falling edge
// - active-low pll reset; high enables the pll
// - lock rises on lock, falls on loss
// - three output clocks reach the global network
// - always-on 10 kHz oscillator reaches global network
// - alternate path, two registers deep, feeds clock, control, pll
package spcs_pkg;
    localparam int unsigned CLK_HZ    = 25_000_000; // core clock, 40 ns
    localparam int unsigned OSC_HZ    = 10_000;     // nominal oscillator
    localparam int unsigned OSC_HALF  = CLK_HZ / (2 * OSC_HZ);
    localparam logic [10:0] OSC_LAST  = 11'(OSC_HALF - 1);
    localparam logic [2:0]  LOCK_REFS = 3'h4;       // stable periods
    localparam logic [15:0] PER_MAX   = 16'hffff;   // no-edge timeout
    // register byte offsets
    localparam logic [7:0] A_PRE    = 8'h00;
    localparam logic [7:0] A_MULT   = 8'h04;
    localparam logic [7:0] A_POST   = 8'h08;
    localparam logic [7:0] A_ODIV_A = 8'h0c;
    localparam logic [7:0] A_ODIV_B = 8'h10;
    localparam logic [7:0] A_ODIV_C = 8'h14;
    localparam logic [7:0] A_ROUTE  = 8'h18;
    localparam logic [7:0] A_STAT   = 8'h1c;
    // reset values
    localparam logic [3:0] RV_PRE  = 4'h1;
    localparam logic [7:0] RV_MULT = 8'h28;
    localparam logic [3:0] RV_POST = 4'h1;
    localparam logic [8:0] RV_ODIV = 9'h002;
    // field positions: route and status words
    localparam int unsigned F_DEST  = 0;  // [1:0] alternate path target
    localparam int unsigned F_AREG  = 2;  // input register option set
    localparam int unsigned F_GSEL  = 3;  // [5:3] global clock source
    localparam int unsigned F_LOCK  = 0;  // lock state
    localparam int unsigned F_STATE = 1;  // [2:1] lock machine
    localparam int unsigned F_PER   = 16; // [31:16] reference period
    // codes
    localparam logic [1:0] DEST_REF   = 2'h0;
    localparam logic [1:0] DEST_GNET  = 2'h1;
    localparam logic [1:0] DEST_CNET  = 2'h2;
    localparam logic [2:0] GS_PAD = 3'h0;
    localparam logic [2:0] GS_OSC = 3'h1;
    localparam logic [2:0] GS_A   = 3'h2;
    localparam logic [2:0] GS_B   = 3'h3;
    localparam logic [2:0] GS_C   = 3'h4;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [1:0] {
        LK_IDLE = 2'b00,
        LK_MEAS = 2'b01,
        LK_RUN  = 2'b10
    } spcs_lock_t;

    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } spcs_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } spcs_axi_rsp_t;

    typedef struct packed {
        logic [2:0] gsel;
        logic       areg;
        logic [1:0] dest;
    } spcs_route_t;

    typedef struct packed {
        logic [31:0] acc;
        logic        first;
        logic        out;
    } spcs_chan_t;

    typedef struct packed {
        spcs_axi_rsp_t  rsp;
        logic           aw_have;
        logic [7:0]     aw_addr;
        logic           w_have;
        logic [31:0]    w_data;
        logic [3:0]     w_strb;
        logic [3:0]     pre;
        logic [7:0]     mult;
        logic [3:0]     post;
        logic [2:0][8:0] odiv;
        spcs_route_t    route;
        logic           pad_s;
        logic           ref_feed;
        logic           ref_prev;
        spcs_lock_t     st;
        logic [15:0]    per_cnt;
        logic [15:0]    per_last;
        logic [2:0]     match;
        logic           lock;
        logic [10:0]    osc_cnt;
        logic           osc;
        logic           gnet;
        logic           cnet;
    } spcs_state_t;
endpackage

/* File: spcs_chan.sv */
`timescale 1ns/1ns
module spcs_chan (
    input  logic        clk,     // core clock
    input  logic        rst_n,   // async reset, active low
    input  logic        ce,      // clock enable
    input  logic        run,     // pll lock_indicator, clock live
    input  logic [7:0]  inc,     // multiplier step per cycle
    input  logic [31:0] thr,     // half-period threshold
    output logic        clk_out  // synthesised clock
);
    import spcs_pkg::*;

    spcs_chan_t  s_q;  // channel state
    spcs_chan_t  s_d;  // next state
    logic [32:0] sum;  // accumulator plus step

    // phase accumulator: toggles once per thr/inc cycles
    always_comb begin
        s_d = s_q;
        sum = {1'b0, s_q.acc} + {25'h0, inc};
        if (ce) begin
            if (!run) begin
                // parked high so the first move is a fall
                s_d.acc   = '0;
                s_d.first = 1'b1;
                s_d.out   = 1'b1;
            end else if (s_q.first) begin
                s_d.first = 1'b0;
                s_d.out   = 1'b0;
            end else if (sum >= {1'b0, thr}) begin
                s_d.acc = 32'(sum - {1'b0, thr});
                s_d.out = ~s_q.out;
            end else begin
                s_d.acc = sum[31:0];
            end
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.first <= 1'b1;
            s_q.out <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign clk_out = s_q.out;
endmodule // spcs_chan

/* File: spcs_top.sv */
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ns
module spcs_top (
    input  logic                    clk,           // core clock 25 MHz
    input  logic                    rst_n,         // async reset, low
    input  logic                    ce,            // clock enable
    input  spcs_pkg::spcs_axi_req_t axi_req,       // axi4-lite request
    output spcs_pkg::spcs_axi_rsp_t axi_rsp,       // axi4-lite answer
    input  logic                    pll_reset_low, // pll reset, low
    input  logic                    gpio_pad_in,   // dedicated pad level
    output logic                    synth_clock_out_a, // pll output a
    output logic                    synth_clock_out_b, // pll output b
    output logic                    synth_clock_out_c, // pll output c
    output logic                    lock_indicator,    // pll lock_indicator
    output logic                    osc_clock_out,     // 10 kHz clock
    output logic                    global_clock_network,  // clock net
    output logic                    global_control_network // control net
);
    import spcs_pkg::*;

    spcs_state_t      s_q;      // all state
    spcs_state_t      s_d;      // next state
    logic [2:0][31:0] thr;      // channel thresholds
    logic [2:0]       ch_out;   // channel clock flops
    logic             wr_go;    // held write executes
    logic             wr_ok;    // write mapped and legal
    logic             wr_map;   // write address mapped
    logic [31:0]      merged;   // strobed write value
    logic [31:0]      cur;      // word before the write
    logic             rise;     // reference rising edge
    logic             close;    // period within one cycle
    logic             path_on;  // alternate path usable
    logic [15:0]      per_dif;  // period difference

    // word offsets the bus answers to
    function automatic logic mapped(input logic [7:0] a);
        case (a)
            A_PRE, A_MULT, A_POST, A_ODIV_A, A_ODIV_B, A_ODIV_C,
            A_ROUTE, A_STAT: mapped = 1'b1;
            default:         mapped = 1'b0;
        endcase
    endfunction

    // power of two within lo..hi
    function automatic logic pow2_in(input logic [31:0] v,
                                     input logic [31:0] lo,
                                     input logic [31:0] hi);
        pow2_in = (v >= lo) && (v <= hi) && ((v & (v - 32'h1)) == '0);
    endfunction

    // bit index of a one-hot divider value
    function automatic logic [3:0] log2_9(input logic [8:0] v);
        log2_9 = '0;
        for (int i = 0; i < 9; i++) begin
            if (v[i]) begin
                log2_9 = 4'(i);
            end
        end
    endfunction

    // register read view, used by reads and strobe merging
    function automatic logic [31:0] rd_val(input logic [7:0] a,
                                           input spcs_state_t s);
        rd_val = '0;
        case (a)
            A_PRE:    rd_val[3:0] = s.pre;
            A_MULT:   rd_val[7:0] = s.mult;
            A_POST:   rd_val[3:0] = s.post;
            A_ODIV_A: rd_val[8:0] = s.odiv[0];
            A_ODIV_B: rd_val[8:0] = s.odiv[1];
            A_ODIV_C: rd_val[8:0] = s.odiv[2];
            A_ROUTE: begin
                rd_val[F_DEST +: 2] = s.route.dest;
                rd_val[F_AREG]      = s.route.areg;
                rd_val[F_GSEL +: 3] = s.route.gsel;
            end
            A_STAT: begin
                rd_val[F_LOCK]      = s.lock;
                rd_val[F_STATE +: 2] = s.st;
                rd_val[F_PER +: 16] = s.per_last;
            end
            default: rd_val = '0;
        endcase
    endfunction

    // illegal settings are refused rather than clipped
    function automatic logic legal(input logic [7:0] a,
                                   input logic [31:0] v);
        case (a)
            A_PRE:   legal = (v >= 32'h1) && (v <= 32'hf);
            A_MULT:  legal = (v >= 32'h1) && (v <= 32'hff);
            A_POST:  legal = pow2_in(v, 32'h1, 32'h8);
            A_ODIV_A, A_ODIV_B, A_ODIV_C:
                     legal = pow2_in(v, 32'h2, 32'h100);
            A_ROUTE: legal = (v[F_DEST +: 2] != 2'h3) &&
                             (v[F_GSEL +: 3] <= GS_C);
            default: legal = 1'b0;
        endcase
    endfunction

    // next-state logic: bus slave, routing, lock machine, oscillator
    always_comb begin
        s_d     = s_q;
        wr_go   = 1'b0;
        wr_ok   = 1'b0;
        wr_map  = 1'b0;
        merged  = '0;
        cur     = rd_val(s_q.aw_addr, s_q);
        path_on = ~s_q.route.areg;
        rise    = s_q.ref_feed & ~s_q.ref_prev;
        per_dif = (s_q.per_cnt >= s_q.per_last) ?
                  s_q.per_cnt - s_q.per_last : s_q.per_last - s_q.per_cnt;
        close   = per_dif <= 16'h0001;
        if (ce) begin
            // address and data are taken in either order
            if (axi_req.awvalid && s_q.rsp.awready) begin
                s_d.aw_have = 1'b1;
                s_d.aw_addr = {axi_req.awaddr[7:2], 2'b00};
            end
            if (axi_req.wvalid && s_q.rsp.wready) begin
                s_d.w_have = 1'b1;
                s_d.w_data = axi_req.wdata;
                s_d.w_strb = axi_req.wstrb;
            end
            if (s_q.rsp.bvalid && axi_req.bready) begin
                s_d.rsp.bvalid = 1'b0;
            end
            wr_go = s_q.aw_have & s_q.w_have & ~s_q.rsp.bvalid;
            if (wr_go) begin
                for (int b = 0; b < 4; b++) begin
                    merged[8*b +: 8] = s_q.w_strb[b] ? s_q.w_data[8*b +: 8]
                                     : cur[8*b +: 8];
                end
                wr_map = mapped(s_q.aw_addr);
                wr_ok  = wr_map && legal(s_q.aw_addr, merged);
                s_d.aw_have    = 1'b0;
                s_d.w_have     = 1'b0;
                s_d.rsp.bvalid = 1'b1;
                s_d.rsp.bresp  = !wr_map ? RESP_DECERR :
                                 wr_ok ? RESP_OKAY : RESP_SLVERR;
                if (wr_ok) begin
                    case (s_q.aw_addr)
                        A_PRE:    s_d.pre     = merged[3:0];
                        A_MULT:   s_d.mult    = merged[7:0];
                        A_POST:   s_d.post    = merged[3:0];
                        A_ODIV_A: s_d.odiv[0] = merged[8:0];
                        A_ODIV_B: s_d.odiv[1] = merged[8:0];
                        A_ODIV_C: s_d.odiv[2] = merged[8:0];
                        default: begin
                            s_d.route.dest = merged[F_DEST +: 2];
                            s_d.route.areg = merged[F_AREG];
                            s_d.route.gsel = merged[F_GSEL +: 3];
                        end
                    endcase
                end
            end
            // reads answer on the edge after the address
            if (s_q.rsp.rvalid && axi_req.rready) begin
                s_d.rsp.rvalid = 1'b0;
            end
            if (axi_req.arvalid && s_q.rsp.arready) begin
                s_d.rsp.rvalid = 1'b1;
                s_d.rsp.rdata  = rd_val({axi_req.araddr[7:2], 2'b00}, s_q);
                s_d.rsp.rresp  = mapped({axi_req.araddr[7:2], 2'b00}) ?
                                 RESP_OKAY : RESP_DECERR;
            end
            s_d.rsp.awready = ~s_d.aw_have & ~s_d.rsp.bvalid;
            s_d.rsp.wready  = ~s_d.w_have & ~s_d.rsp.bvalid;
            s_d.rsp.arready = ~s_d.rsp.rvalid;

            // pad passes through two registers on the alternate path
            s_d.pad_s = gpio_pad_in;
            s_d.ref_feed = path_on & (s_q.route.dest == DEST_REF) &
                           s_q.pad_s;
            // alternate path onto the control net
            s_d.cnet = path_on & (s_q.route.dest == DEST_CNET) &
                       s_q.pad_s;
            s_d.ref_prev = s_q.ref_feed;

            if (!pll_reset_low) begin
                s_d.st      = LK_IDLE;
                s_d.per_cnt = '0;
                s_d.match   = '0;
            end else begin
                unique case (s_q.st)
                    LK_IDLE: begin
                        s_d.st      = LK_MEAS;
                        s_d.per_cnt = '0;
                        s_d.match   = '0;
                    end
                    LK_MEAS, LK_RUN: begin
                        if (rise) begin
                            s_d.per_cnt = 16'h0001;
                            // lock on steady period, drop on drift
                            if (s_q.st == LK_MEAS) begin
                                s_d.per_last = s_q.per_cnt;
                                s_d.match = close ? s_q.match + 3'h1 : '0;
                                if (close && s_q.match + 3'h1 >= LOCK_REFS)
                                begin
                                    s_d.st = LK_RUN;
                                end
                            end else if (!close) begin
                                s_d.st    = LK_MEAS;
                                s_d.match = '0;
                            end
                        end else if (s_q.per_cnt == PER_MAX) begin
                            s_d.st      = LK_MEAS;
                            s_d.match   = '0;
                            s_d.per_cnt = '0;
                        end else begin
                            s_d.per_cnt = s_q.per_cnt + 16'h0001;
                        end
                    end
                    default: s_d.st = LK_IDLE;
                endcase
                // new settings need a fresh lock
                if (wr_ok && s_d.st != LK_IDLE) begin
                    s_d.st    = LK_MEAS;
                    s_d.match = '0;
                end
            end
            s_d.lock = (s_d.st == LK_RUN);

            if (s_q.osc_cnt == OSC_LAST) begin
                s_d.osc_cnt = '0;
                s_d.osc     = ~s_q.osc;
            end else begin
                s_d.osc_cnt = s_q.osc_cnt + 11'h001;
            end

            case (s_q.route.gsel)
                GS_OSC:  s_d.gnet = s_q.osc;
                GS_A:    s_d.gnet = ch_out[0];
                GS_B:    s_d.gnet = ch_out[1];
                GS_C:    s_d.gnet = ch_out[2];
                // alternate path onto the clock net
                default: s_d.gnet = path_on &
                         (s_q.route.dest == DEST_GNET) & s_q.pad_s;
            endcase
        end
    end

    // state register; only constants under reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.pre <= RV_PRE;
            s_q.mult <= RV_MULT;
            s_q.post <= RV_POST;
            s_q.odiv <= {3{RV_ODIV}};
            s_q.st <= LK_IDLE;
            s_q.rsp.awready <= 1'b1;
            s_q.rsp.wready <= 1'b1;
            s_q.rsp.arready <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    for (genvar i = 0; i < 3; i++) begin : g_ch
        assign thr[i] = (32'(s_q.per_last) * 32'(s_q.pre)) <<
                        (log2_9({5'h0, s_q.post}) + log2_9(s_q.odiv[i])
                         - 4'h1);
        spcs_chan u_ch (
            .clk     (clk),
            .rst_n   (rst_n),
            .ce      (ce),
            .run     (s_q.lock),
            .inc     (s_q.mult),
            .thr     (thr[i]),
            .clk_out (ch_out[i])
        );
    end

    assign axi_rsp                = s_q.rsp;
    assign synth_clock_out_a      = ch_out[0];
    assign synth_clock_out_b      = ch_out[1];
    assign synth_clock_out_c      = ch_out[2];
    assign lock_indicator         = s_q.lock;
    assign osc_clock_out          = s_q.osc;
    assign global_clock_network   = s_q.gnet;
    assign global_control_network = s_q.cnet;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_reset_drops_lock: assert property (
        (ce && !pll_reset_low) |=> !lock_indicator)
        else $error("lock stayed high under pll reset");
    a_lock_after_meas: assert property (
        $rose(lock_indicator) |-> $past(s_q.st) == LK_MEAS)
        else $error("lock rose outside measurement");
    a_timeout_unlock: assert property (
        (ce && pll_reset_low && s_q.st == LK_RUN && !rise &&
         s_q.per_cnt == PER_MAX) |=> !lock_indicator)
        else $error("lock held after reference loss");
    a_div_ranges: assert property (
        s_q.pre != 4'h0 && s_q.mult != 8'h00)
        else $error("pre-divider or multiplier out of range");
    a_pow2_dividers: assert property (
        pow2_in(32'(s_q.post), 32'h1, 32'h8) &&
        pow2_in(32'(s_q.odiv[0]), 32'h2, 32'h100))
        else $error("post or output divider illegal");
    a_bad_write_err: assert property (
        (wr_go && wr_map && !wr_ok) |=> (axi_rsp.bvalid &&
        axi_rsp.bresp == RESP_SLVERR && $stable(s_q.pre) &&
        $stable(s_q.mult) && $stable(s_q.post)))
        else $error("illegal write not refused");
    a_falls_aligned: assert property (
        ($rose(lock_indicator) && ce) |=> ch_out == 3'b000)
        else $error("outputs did not fall together");
    a_idle_outs_high: assert property (
        (ce && !lock_indicator) |=> ch_out == 3'b111)
        else $error("outputs moved while unlocked");
    a_osc_toggle: assert property (
        (ce && s_q.osc_cnt == OSC_LAST) |=> $changed(osc_clock_out))
        else $error("oscillator missed its half period");
    a_ref_only_alt: assert property (
        (ce && (s_q.route.areg || s_q.route.dest != DEST_REF))
        |=> !s_q.ref_feed)
        else $error("reference fed while not routed");

    c_lock_rise: cover property ($rose(lock_indicator));
    c_lock_loss: cover property ($fell(lock_indicator) && pll_reset_low);
    c_slverr: cover property (axi_rsp.bvalid &&
                              axi_rsp.bresp == RESP_SLVERR);
    c_gnet_osc: cover property (s_q.route.gsel == GS_OSC &&
                                $rose(global_clock_network));
endmodule // spcs_top

/* File: spcs_core_model.sv */
`timescale 1ns/1ns
module spcs_core_model (
    input  wire logic clk,        // core clock
    input  wire logic ref_on,     // run the reference
    input  wire logic hold_reset, // ask for a pll reset
    input  wire logic lock_in,    // raw lock
    input  wire logic out_a,      // pll output a
    output logic      pad,        // reference pad level
    output logic      rst_low,    // pll reset, low
    output logic      lock_sync,  // lock in this domain
    output logic      clk_a_inv   // output a, inverted
);
    logic meta_q; // first synchroniser stage
    // reference: 10 clk period, edges away from clk rise
    initial pad = 1'b0;
    always #200 pad = ref_on ? ~pad : 1'b0;
    assign rst_low = ~hold_reset;
    // two flops, lock is asynchronous here
    always_ff @(posedge clk) begin
        meta_q    <= lock_in;
        lock_sync <= meta_q;
    end
    // rising-edge users need the falling edge
    assign clk_a_inv = ~out_a;
endmodule // spcs_core_model

/* File: test_simple_pll_clock_source.sv */
`timescale 1ns/1ns
module test_simple_pll_clock_source;
    import spcs_pkg::*;
    logic          clk = 1'b0;      // core clock
    logic          rst_n = 1'b0;    // block reset
    logic          ref_on = 1'b0;   // reference running
    logic          hold_rst = 1'b0; // pll reset request
    spcs_axi_req_t req = '0;        // bus request
    spcs_axi_rsp_t rsp;             // bus answer
    logic          pad, rst_low, lock, lock_s, inv_a;
    logic [5:0]    outs;            // osc, control, clock, c, b, a
    logic          ce = 1'b1;       // clock enable
    logic [1:0]    er;              // expected write answer
    logic [31:0]   rd;              // last read word
    int            bad_count = 0;
    int            checks_done = 0;
    int            n;
    // writes: illegal ones leave the old value in place
    logic [7:0]  wa[17] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h0c, 8'h10,
        8'h18, 8'h18, 8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h00, 8'h04,
        8'h08, 8'h0c};
    logic [31:0] wd[17] = '{0, 0, 3, 3, 'h180, 1, 3, 'h28, 'hf, 'hff,
        8, 'h100, 4, 1, 1, 1, 2};
    logic [31:0] wx[17] = '{1, 'h28, 1, 2, 2, 2, 0, 0, 'hf, 'hff, 8,
        'h100, 4, 1, 1, 1, 2};

    spcs_top DUT (.clk(clk), .rst_n(rst_n), .ce(ce), .axi_req(req),
        .axi_rsp(rsp), .pll_reset_low(rst_low), .gpio_pad_in(pad),
        .synth_clock_out_a(outs[0]), .synth_clock_out_b(outs[1]),
        .synth_clock_out_c(outs[2]), .lock_indicator(lock),
        .osc_clock_out(outs[5]), .global_clock_network(outs[3]),
        .global_control_network(outs[4]));
    spcs_core_model core (.clk(clk), .ref_on(ref_on),
        .hold_reset(hold_rst), .lock_in(lock), .out_a(outs[0]),
        .pad(pad), .rst_low(rst_low), .lock_sync(lock_s),
        .clk_a_inv(inv_a));

    always #20 clk = ~clk;

    task automatic chk(input string what, input logic [31:0] e,
                       input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic conclude;
        if (bad_count == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // write: address and data offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] e);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge clk);
            aw = aw | (rsp.awready === 1'b1);
            w = w | (rsp.wready === 1'b1);
            if (aw) req.awvalid <= 1'b0;
            if (w) req.wvalid <= 1'b0;
        end
        do @(posedge clk); while (rsp.bvalid !== 1'b1);
        // bready stays up so a second write may follow at once
        chk("bresp", 32'(e), 32'(rsp.bresp));
    endtask

    task automatic rdw(input logic [7:0] a, input logic [1:0] e);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        do @(posedge clk); while (rsp.arready !== 1'b1);
        req.arvalid <= 1'b0;
        do @(posedge clk); while (rsp.rvalid !== 1'b1);
        req.rready <= 1'b0;
        rd = rsp.rdata;
        chk("rresp", 32'(e), 32'(rsp.rresp));
    endtask

    // period of outs[i] in clk, fall to fall
    task automatic per(input int i, input int e);
        int k;
        k = 0;
        while (outs[i] !== 1'b1) @(posedge clk);
        while (outs[i] !== 1'b0) @(posedge clk);
        do begin @(posedge clk); k++; end while (outs[i] !== 1'b1);
        do begin @(posedge clk); k++; end while (outs[i] !== 1'b0);
        chk("period", 32'(e), 32'(k));
    endtask

    // wait for lock, bounded so a dead loop cannot hang the run
    task automatic wait_lock;
        n = 0;
        while (lock !== 1'b1 && n < 400) begin
            @(posedge clk);
            n++;
        end
        chk("lock_indicator", 1, 32'(lock));
    endtask

    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        // last legal settings keep the scaled loop in range
        for (int i = 0; i < 17; i++) begin
            er = (wd[i] === wx[i]) ? RESP_OKAY : RESP_SLVERR;
            wr(wa[i], wd[i], er);
            rdw(wa[i], RESP_OKAY);
            chk("setting", wx[i], rd);
        end
        wr(A_STAT, 1, RESP_SLVERR);
        wr(8'h20, 0, RESP_DECERR);
        rdw(8'h20, RESP_DECERR);
        chk("unmapped", 0, rd);
        // lock on the pad reference, then all outputs fall together
        ref_on <= 1'b1;
        wait_lock;
        @(posedge clk);
        chk("aligned", 0, 32'(outs[2:0]));
        chk("inverted a", 1, 32'(inv_a));
        rdw(A_STAT, RESP_OKAY);
        chk("status", 32'h000a_0005, rd);
        chk("lock sync", 1, 32'(lock_s));
        per(0, 20);
        per(1, 40);
        per(2, 20);
        // clock enable low: every output holds its level
        ce <= 1'b0;
        @(posedge clk);
        rd = 32'(outs);
        repeat (30) @(posedge clk);
        chk("frozen", rd, 32'(outs));
        ce <= 1'b1;
        hold_rst <= 1'b1;
        repeat (3) @(posedge clk);
        chk("lock in reset", 0, 32'(lock));
        chk("outs in reset", 7, 32'(outs[2:0]));
        hold_rst <= 1'b0;
        // alternate path to the control net: the pll never sees it
        wr(A_ROUTE, 2, RESP_OKAY);
        repeat (300) @(posedge clk);
        chk("lock off", 0, 32'(lock));
        per(4, 10);
        // register option set: the control net goes quiet
        wr(A_ROUTE, 'he, RESP_OKAY);
        repeat (10) @(posedge clk);
        chk("register option", 0, 32'(outs[4]));
        per(3, 2500);
        per(5, 2500);
        // alternate path to the clock net
        wr(A_ROUTE, 1, RESP_OKAY);
        per(3, 10);
        // channel b onto the clock net after a fresh lock
        wr(A_ROUTE, 'h18, RESP_OKAY);
        wait_lock;
        per(3, 40);
        conclude;
    end

    // watchdog: the run needs under 12000 cycles
    initial begin
        #(40 * 20000);
        bad_count++;
        conclude;
    end
endmodule // test_simple_pll_clock_source
